// ---- src/t2m12_pkg.sv ----
// shared constants for the T1-to-T2 M12 stage
package t2m12_pkg;
    localparam int unsigned TRIBS       = 4;   // T1 tributaries
    localparam int unsigned SUBFRAMES   = 4;   // M subframes per M frame
    localparam int unsigned BLOCKS      = 6;   // blocks per subframe
    localparam int unsigned BLOCK_BITS  = 49;  // overhead bit plus payload
    localparam int unsigned FIFO_DEPTH  = 32;  // words per tributary buffer
    localparam int unsigned STUFF_LEVEL = 16;  // stuff when fill below this
    // T2 bit timing at the 200 MHz system clock
    localparam int unsigned CLK_MHZ     = 200;
    localparam int unsigned T2_KBPS     = 6312;
    localparam int unsigned BIT_DIV     = (CLK_MHZ * 1000) / T2_KBPS;
    // overhead block slots inside a subframe
    localparam logic [2:0]  BLK_M       = 3'h0;
    localparam logic [2:0]  BLK_C1      = 3'h1;
    localparam logic [2:0]  BLK_F1      = 3'h2;
    localparam logic [2:0]  BLK_C2      = 3'h3;
    localparam logic [2:0]  BLK_C3      = 3'h4;
    localparam logic [2:0]  BLK_F2      = 3'h5;
    // fixed alignment values
    localparam logic        M1_VAL      = 1'h0;
    localparam logic        M2_VAL      = 1'h1;
    localparam logic        M3_VAL      = 1'h1;
    localparam logic        F1_VAL      = 1'h0;
    localparam logic        F2_VAL      = 1'h1;
endpackage

// ---- src/t2m12_if.sv ----
// T2 bit stream between the multiplexer and the receiving end
`timescale 1ns/100ps
interface t2m12_if;
    logic t2_data;   // one T2 bit
    logic t2_valid;  // bit strobe
    logic t2_sof;    // marks the first bit of an M frame
    modport mux (output t2_data, output t2_valid, output t2_sof);
    modport demux (input t2_data, input t2_valid, input t2_sof);
endinterface // t2m12_if

// ---- src/t2m12_fifo.sv ----
// parameterised valid/ready FIFO used per tributary
`timescale 1ns/100ps
module t2m12_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic                       clock_i,
    input  wire logic                       resetn_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [WIDTH-1:0]                out_data_o,
    output logic [$clog2(DEPTH):0]          level_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // handshakes on both sides
    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign level_o     = cnt_q;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // t2m12_fifo

// ---- src/t2m12_mux.sv ----
// M12 multiplexer: four asynchronous T1 lines into the T2 M frame
// Function
// - subframes sent cyclically 1, 2, 3, 4
// - six blocks of 49 bits each
// - first block bit overhead, 48 payload
// - M bits fixed 0, 1, 1
// - F bits fixed 0 then 1
// - all-one C means stuffed, majority decode
// - inverted third C bit requests loopback
// - X bit 0 while receive framer unsynchronized
// - payload interleaves tributaries 1 to 4
// - twelve bits per tributary per block
// - tributaries 2 and 4 sent inverted
// - tributaries asynchronous, no T1 framing passed
// - last block carries the stuff position
// - stuff position moves with the subframe
`timescale 1ns/100ps
module t2m12_mux
    import t2m12_pkg::*;
#(
    parameter int unsigned DEPTH     = t2m12_pkg::FIFO_DEPTH,
    parameter int unsigned THRESHOLD = t2m12_pkg::STUFF_LEVEL,
    parameter int unsigned DIVIDER   = t2m12_pkg::BIT_DIV
) (
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    input  wire logic [TRIBS-1:0]    trib_clk_i,
    input  wire logic [TRIBS-1:0]    trib_data_i,
    output logic      [TRIBS-1:0]    trib_ready_o,
    input  wire logic [TRIBS-1:0]    loop_req_i,
    input  wire logic                rx_sync_i,
    t2m12_if.mux                     t2
);
    import t2m12_pkg::*;
    localparam int unsigned LW = $clog2(DEPTH) + 1;

    logic [TRIBS-1:0] clk_s1_q;
    logic [TRIBS-1:0] clk_s2_q;
    logic [TRIBS-1:0] clk_s3_q;
    logic [TRIBS-1:0] dat_s1_q;
    logic [TRIBS-1:0] dat_s2_q;
    logic [TRIBS-1:0] push;
    logic [TRIBS-1:0] f_ready;
    logic [TRIBS-1:0] f_valid;
    logic [TRIBS-1:0] f_data;
    logic [TRIBS-1:0] pop;
    logic [LW-1:0]    f_level [TRIBS];
    logic [$clog2(DIVIDER)-1:0] div_q;
    logic             tick;
    logic [1:0]       sf_q;
    logic [2:0]       blk_q;
    logic [5:0]       bit_q;
    logic             stuff_q;
    logic             loop_q;
    logic             ovh_bit;
    logic             info_bit;
    logic             stuff_slot;
    logic [1:0]       trib;
    logic             t2_data_q;
    logic             t2_valid_q;
    logic             t2_sof_q;
    logic [TRIBS-1:0] trib_ready_q;

    // per-tributary pin synchronisers, edge capture and buffering
    genvar g;
    generate
        for (g = 0; g < TRIBS; g++) begin : g_trib
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    clk_s1_q[g] <= 1'b0;
                    clk_s2_q[g] <= 1'b0;
                    clk_s3_q[g] <= 1'b0;
                    dat_s1_q[g] <= 1'b0;
                    dat_s2_q[g] <= 1'b0;
                end else begin
                    clk_s1_q[g] <= trib_clk_i[g];
                    clk_s2_q[g] <= clk_s1_q[g];
                    clk_s3_q[g] <= clk_s2_q[g];
                    dat_s1_q[g] <= trib_data_i[g];
                    dat_s2_q[g] <= dat_s1_q[g];
                end
            end
            // rising tributary clock takes one raw bit, framing untouched
            assign push[g] = clk_s2_q[g] && !clk_s3_q[g];
            assign pop[g]  = tick && info_bit && !stuff_slot
                             && (trib == 2'(g));
            t2m12_fifo #(
                .WIDTH (1),
                .DEPTH (DEPTH)
            ) u_fifo (
                .clock_i     (clock_i),
                .resetn_i    (resetn_i),
                .in_valid_i  (push[g]),
                .in_ready_o  (f_ready[g]),
                .in_data_i   (dat_s2_q[g]),
                .out_valid_o (f_valid[g]),
                .out_ready_i (pop[g]),
                .out_data_o  (f_data[g]),
                .level_o     (f_level[g])
            );
        end
    endgenerate

    // T2 bit rate divider
    assign tick = (div_q == ($clog2(DIVIDER))'(DIVIDER - 1));
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
        end
    end

    // frame position: bit in block, block in subframe, subframe in frame
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sf_q  <= '0;
            blk_q <= '0;
            bit_q <= '0;
        end else if (tick) begin
            if (bit_q == 6'(BLOCK_BITS - 1)) begin
                bit_q <= '0;
                if (blk_q == 3'(BLOCKS - 1)) begin
                    blk_q <= '0;
                    sf_q  <= sf_q + 1'b1;
                end else begin
                    blk_q <= blk_q + 1'b1;
                end
            end else begin
                bit_q <= bit_q + 1'b1;
            end
        end
    end

    // stuff and loopback choice taken once at each subframe start
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stuff_q <= 1'b0;
            loop_q  <= 1'b0;
        end else if (tick && bit_q == '0 && blk_q == BLK_M) begin
            stuff_q <= (f_level[sf_q] < LW'(THRESHOLD));
            loop_q  <= loop_req_i[sf_q];
        end
    end

    // position decode
    assign info_bit   = (bit_q != '0);
    assign trib       = 2'(bit_q - 6'h01);
    assign stuff_slot = stuff_q && (blk_q == BLK_F2)
                        && (bit_q == 6'(sf_q) + 6'h01);

    // overhead bit value for the current block
    always_comb begin
        ovh_bit = 1'b0;
        case (blk_q)
            BLK_M: begin
                case (sf_q)
                    2'h0:    ovh_bit = rx_sync_i;
                    2'h1:    ovh_bit = M1_VAL;
                    2'h2:    ovh_bit = M2_VAL;
                    default: ovh_bit = M3_VAL;
                endcase
            end
            BLK_C1:  ovh_bit = stuff_q;
            BLK_F1:  ovh_bit = F1_VAL;
            BLK_C2:  ovh_bit = stuff_q;
            BLK_C3:  ovh_bit = stuff_q ^ loop_q;
            BLK_F2:  ovh_bit = F2_VAL;
            default: ovh_bit = 1'b0;
        endcase
    end

    // serial output, stuffed slots send zero, underruns zero on tributaries 1 and 3, one on 2 and 4
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            t2_data_q  <= 1'b0;
            t2_valid_q <= 1'b0;
            t2_sof_q   <= 1'b0;
        end else begin
            t2_valid_q <= tick;
            t2_sof_q   <= tick && sf_q == '0 && blk_q == '0
                          && bit_q == '0;
            if (tick) begin
                if (!info_bit) begin
                    t2_data_q <= ovh_bit;
                end else if (stuff_slot) begin
                    t2_data_q <= 1'b0;
                end else begin
                    t2_data_q <= (f_valid[trib] & f_data[trib])
                                 ^ trib[0];
                end
            end
        end
    end

    // registered back-pressure toward each tributary source
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trib_ready_q <= '0;
        end else begin
            trib_ready_q <= f_ready;
        end
    end

    assign trib_ready_o = trib_ready_q;
    assign t2.t2_data   = t2_data_q;
    assign t2.t2_valid  = t2_valid_q;
    assign t2.t2_sof    = t2_sof_q;
endmodule // t2m12_mux

// ---- src/t2m12_demux.sv ----
// receiving end: checks alignment, decodes C bits, splits tributaries
`timescale 1ns/100ps
module t2m12_demux
    import t2m12_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    t2m12_if.demux                   t2,
    output logic [TRIBS-1:0]         trib_data_o,
    output logic [TRIBS-1:0]         trib_valid_o,
    output logic [TRIBS-1:0]         loop_o,
    output logic                     sync_o,
    output logic                     far_alarm_o
);
    import t2m12_pkg::*;

    logic [1:0]       sf_q;
    logic [2:0]       blk_q;
    logic [5:0]       bit_q;
    logic [1:0]       sf;
    logic [2:0]       blk;
    logic [5:0]       bitn;
    logic [2:0]       c_q;
    logic             stuffed_q;
    logic             err_q;
    logic             sync_q;
    logic             far_q;
    logic [TRIBS-1:0] loop_q;
    logic [TRIBS-1:0] tdata_q;
    logic [TRIBS-1:0] tvalid_q;
    logic             mism;
    logic             vote;
    logic             loop_code;
    logic [1:0]       trib;

    // frame start forces the position to the first bit
    assign sf   = t2.t2_sof ? 2'h0 : sf_q;
    assign blk  = t2.t2_sof ? 3'h0 : blk_q;
    assign bitn = t2.t2_sof ? 6'h00 : bit_q;
    assign trib = 2'(bitn - 6'h01);
    // majority of the C bits, loopback when only C3 differs
    assign vote      = (c_q[0] & c_q[1]) | (c_q[0] & c_q[2])
                       | (c_q[1] & c_q[2]);
    assign loop_code = (c_q[0] == c_q[1]) && (c_q[2] != c_q[0]);

    // alignment mismatch on the fixed overhead bits
    always_comb begin
        mism = 1'b0;
        if (bitn == '0) begin
            if (blk == BLK_M && sf == 2'h1) begin
                mism = (t2.t2_data != M1_VAL);
            end else if (blk == BLK_M && sf != 2'h0) begin
                mism = (t2.t2_data != M2_VAL);
            end else if (blk == BLK_F1) begin
                mism = (t2.t2_data != F1_VAL);
            end else if (blk == BLK_F2) begin
                mism = (t2.t2_data != F2_VAL);
            end
        end
    end

    // position counters advance with each received bit
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sf_q  <= '0;
            blk_q <= '0;
            bit_q <= '0;
        end else if (t2.t2_valid) begin
            if (bitn == 6'(BLOCK_BITS - 1)) begin
                bit_q <= '0;
                if (blk == 3'(BLOCKS - 1)) begin
                    blk_q <= '0;
                    sf_q  <= sf + 1'b1;
                end else begin
                    blk_q <= blk + 1'b1;
                    sf_q  <= sf;
                end
            end else begin
                bit_q <= bitn + 6'h01;
                blk_q <= blk;
                sf_q  <= sf;
            end
        end
    end

    // overhead capture, C decoding and framing state
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            c_q       <= '0;
            stuffed_q <= 1'b0;
            err_q     <= 1'b0;
            sync_q    <= 1'b0;
            far_q     <= 1'b0;
            loop_q    <= '0;
        end else if (t2.t2_valid) begin
            if (t2.t2_sof) begin
                sync_q <= !err_q;
                err_q  <= mism;
            end else if (mism) begin
                err_q <= 1'b1;
            end
            if (bitn == '0) begin
                case (blk)
                    BLK_M:  far_q <= (sf == 2'h0) ? !t2.t2_data : far_q;
                    BLK_C1: c_q[0] <= t2.t2_data;
                    BLK_C2: c_q[1] <= t2.t2_data;
                    BLK_C3: c_q[2] <= t2.t2_data;
                    BLK_F2: begin
                        // loopback code keeps C1/C2 as the stuff choice
                        stuffed_q <= loop_code ? c_q[0] : vote;
                        loop_q[sf] <= loop_code;
                    end
                    default: c_q <= c_q;
                endcase
            end
        end
    end

    // payload split: stuffed slot dropped, 2 and 4 restored
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tdata_q  <= '0;
            tvalid_q <= '0;
        end else begin
            tvalid_q <= '0;
            if (t2.t2_valid && bitn != '0) begin
                if (!(stuffed_q && blk == BLK_F2
                      && bitn == 6'(sf) + 6'h01)) begin
                    tvalid_q[trib] <= 1'b1;
                    tdata_q[trib]  <= t2.t2_data ^ trib[0];
                end
            end
        end
    end

    assign trib_data_o  = tdata_q;
    assign trib_valid_o = tvalid_q;
    assign loop_o       = loop_q;
    assign sync_o       = sync_q;
    assign far_alarm_o  = far_q;
endmodule // t2m12_demux

// ---- verification/t2m12_sva.sv ----
// assertions on the T2 stream between multiplexer and receiver
`timescale 1ns/100ps
module t2m12_sva
    import t2m12_pkg::*;
#(
    parameter int unsigned DIVIDER = t2m12_pkg::BIT_DIV
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic t2_data,
    input wire logic t2_valid,
    input wire logic t2_sof
);
    logic [10:0] pos_q;
    logic [10:0] idx;
    logic [8:0]  off;
    logic [1:0]  sub;
    logic [2:0]  blk;
    logic        hit;
    logic        last;
    logic        mexp;
    logic        seen_q;
    logic        c1_q;
    logic [7:0]  gap_q;
    logic        run_q;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    // where the bit now on the wire sits in the M frame
    always_comb begin
        idx  = t2_sof ? 11'h000 : pos_q + 11'h001;
        sub  = 2'(idx / 11'h126);
        off  = 9'(idx % 11'h126);
        blk  = 3'(off / 9'h031);
        hit  = seen_q && t2_valid && (off % 9'h031) == 9'h000;
        last = pos_q == 11'h497;
        mexp = (sub == 2'h1) ? M1_VAL : (sub == 2'h2) ? M2_VAL : M3_VAL;
    end

    // frame position and first C bit of the running subframe
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pos_q  <= 11'h000;
            seen_q <= 1'b0;
            c1_q   <= 1'b0;
        end else if (t2_valid) begin
            pos_q  <= idx;
            seen_q <= seen_q | t2_sof;
            if (hit && blk == BLK_C1) begin
                c1_q <= t2_data;
            end
        end
    end

    // cycles since the last bit strobe
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap_q <= 8'h00;
            run_q <= 1'b0;
        end else if (t2_valid) begin
            gap_q <= 8'h01;
            run_q <= 1'b1;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end

    a_sof_with_strobe: assert property (t2_sof |-> t2_valid)
        else $error("frame start without bit strobe");
    a_strobe_single: assert property (t2_valid |=> !t2_valid)
        else $error("bit strobe wider than one cycle");
    a_strobe_period: assert property (
        t2_valid && run_q |-> gap_q == 8'(DIVIDER))
        else $error("bit strobe spacing wrong");
    a_frame_length: assert property (
        seen_q && t2_valid |-> t2_sof == last)
        else $error("frame length is not 1176 bits");
    a_m_align: assert property (
        hit && blk == BLK_M && sub != 2'h0 |-> t2_data == mexp)
        else $error("subframe alignment bit wrong");
    a_f1_align: assert property (
        hit && blk == BLK_F1 |-> t2_data == F1_VAL)
        else $error("first frame alignment bit wrong");
    a_f2_align: assert property (
        hit && blk == BLK_F2 |-> t2_data == F2_VAL)
        else $error("second frame alignment bit wrong");
    a_c_agree: assert property (
        hit && blk == BLK_C2 |-> t2_data == c1_q)
        else $error("second C bit differs from first");

    c_frame: cover property (t2_sof);
    c_stuffed: cover property (hit && blk == BLK_C1 && t2_data);
    c_loop: cover property (hit && blk == BLK_C3 && t2_data != c1_q);
endmodule // t2m12_sva

// ---- verification/t2_m12_multiplexer_test.sv ----
// self-checking bench: multiplexer and receiver back to back
`timescale 1ns/100ps
module t2_m12_multiplexer_test;
    import t2m12_pkg::*;
    localparam int unsigned DIV = 3;  // shortened bit period
    logic             clock_i;
    logic             resetn_i;
    logic [TRIBS-1:0] trib_clk_i = 4'h0; // idle low before the first toggle
    logic [TRIBS-1:0] trib_data_i;
    logic [TRIBS-1:0] trib_ready_o;
    logic [TRIBS-1:0] loop_req_i;
    logic             rx_sync_i;
    logic [TRIBS-1:0] trib_data_o;
    logic [TRIBS-1:0] trib_valid_o;
    logic [TRIBS-1:0] loop_o;
    logic             sync_o;
    logic             far_alarm_o;
    logic [TRIBS-1:0] feed_on;
    logic             last_x;
    int               half [TRIBS] = '{3, 4, 5, 4};
    int               tick [TRIBS];
    int               acc  [SUBFRAMES][TRIBS];
    int               snap [SUBFRAMES][TRIBS];
    int               ones [TRIBS];
    int               ones_s [TRIBS];
    int               pos, wbad, wbad_s, fails, checks;

    t2m12_if i_t2m12_if ();
    t2m12_mux #(.DIVIDER(DIV)) i_t2m12_mux (
        .clock_i      (clock_i),
        .resetn_i     (resetn_i),
        .trib_clk_i   (trib_clk_i),
        .trib_data_i  (trib_data_i),
        .trib_ready_o (trib_ready_o),
        .loop_req_i   (loop_req_i),
        .rx_sync_i    (rx_sync_i),
        .t2           (i_t2m12_if)
    );
    t2m12_demux i_t2m12_demux (
        .clock_i      (clock_i),
        .resetn_i     (resetn_i),
        .t2           (i_t2m12_if),
        .trib_data_o  (trib_data_o),
        .trib_valid_o (trib_valid_o),
        .loop_o       (loop_o),
        .sync_o       (sync_o),
        .far_alarm_o  (far_alarm_o)
    );
    t2m12_sva #(.DIVIDER(DIV)) i_t2m12_sva (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .t2_data  (i_t2m12_if.t2_data),
        .t2_valid (i_t2m12_if.t2_valid),
        .t2_sof   (i_t2m12_if.t2_sof)
    );

    // 200 MHz system clock
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // tributary clocks, each at the rate set by its half entry while feeding
    always @(negedge clock_i) begin
        for (int t = 0; t < TRIBS; t++) begin
            tick[t] = tick[t] + 1;
            if (tick[t] >= half[t]) begin
                tick[t] = 0;
                trib_clk_i[t] <= feed_on[t] & ~trib_clk_i[t];
            end
        end
    end

    // frame position, recovered bit counts and payload bit check
    always @(posedge clock_i) begin : mon
        int k;
        if (i_t2m12_if.t2_valid === 1'b1) begin
            pos = (i_t2m12_if.t2_sof === 1'b1) ? 0 : pos + 1;
            k = (pos % 49 + 3) % 4;
            if (pos == 0) begin
                last_x = i_t2m12_if.t2_data;
                snap = acc;
                ones_s = ones;
                wbad_s = wbad;
                acc = '{default: 0};
                ones = '{default: 0};
                wbad = 0;
            end else if (pos % 49 != 0 &&
                i_t2m12_if.t2_data !== (trib_data_i[k] ^ k[0])) begin
                wbad++;
            end
        end
        for (int t = 0; t < TRIBS; t++) begin
            if (trib_valid_o[t] === 1'b1) begin
                acc[pos / 294][t]++;
                ones[t] += trib_data_o[t];
            end
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("BAD %s expected %0d seen %0d", what, exp, got);
            fails++;
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // waits for n frame starts, bounded
    task automatic wait_sof(input int n);
        int seen;
        seen = 0;
        for (int k = 0; k < 4000 * n && seen < n; k++) begin
            @(posedge clock_i);
            if (i_t2m12_if.t2_sof === 1'b1) begin
                seen++;
            end
        end
        repeat (4) @(negedge clock_i);
        if (seen < n) begin
            $display("BAD frame start expected %0d seen %0d", n, seen);
            fails++;
            wrap_up();
        end
    endtask

    task automatic t_reset;
        chk("ready in reset", 4'h0, trib_ready_o);
        chk("strobe in reset", 1'b0, i_t2m12_if.t2_valid);
    endtask

    task automatic t_alarm;
        rx_sync_i = 1'b0;
        wait_sof(2);
        chk("x bit", 1'b0, last_x);
        chk("far alarm", 1'b1, far_alarm_o);
        chk("frame sync", 1'b1, sync_o);
        rx_sync_i = 1'b1;
        wait_sof(2);
        chk("x bit", 1'b1, last_x);
        chk("far alarm", 1'b0, far_alarm_o);
    endtask

    task automatic t_data;
        logic [TRIBS-1:0] full;
        full = 4'h0;
        for (int k = 0; k < 2000; k++) begin
            @(negedge clock_i);
            full = full | ~trib_ready_o;
        end
        chk("buffers refused", 4'hF, full);
        wait_sof(2);
        chk("payload errors", 0, wbad_s);
        for (int t = 0; t < TRIBS; t++) begin
            chk("ones", (t < 2) ? 288 : 0, ones_s[t]);
            for (int s = 0; s < SUBFRAMES; s++) begin
                chk("bits per subframe", 72, snap[s][t]);
            end
        end
    endtask

    task automatic t_stuff;
        feed_on = 4'h0;
        wait_sof(3);
        chk("ready when empty", 4'hF, trib_ready_o);
        for (int t = 0; t < TRIBS; t++) begin
            for (int s = 0; s < SUBFRAMES; s++) begin
                chk("stuffed count", (s == t) ? 71 : 72,
                    snap[s][t]);
            end
        end
        feed_on = 4'hF;
    endtask

    task automatic t_loop;
        for (int n = 0; n < TRIBS; n++) begin
            loop_req_i = 4'h1 << n;
            wait_sof(2);
            chk("loop flags", 4'h1 << n, loop_o);
        end
        loop_req_i = 4'h0;
        wait_sof(2);
        chk("loop flags", 4'h0, loop_o);
    endtask

    // reset, then the scenarios in turn
    initial begin
        resetn_i = 1'b0;
        trib_data_i = 4'h3;
        loop_req_i = 4'h0;
        rx_sync_i = 1'b1;
        feed_on = 4'hF;
        repeat (3) @(negedge clock_i);
        t_reset();
        resetn_i = 1'b1;
        t_alarm();
        t_data();
        t_stuff();
        t_loop();
        wrap_up();
    end
endmodule // t2_m12_multiplexer_test
